/* File: fault_monitor_defines.svh */
// Offsets, reset values and timing counts for the fault monitor and lamp controller
`ifndef FAULT_MONITOR_DEFINES_SVH
`define FAULT_MONITOR_DEFINES_SVH

// Clock rate in kHz (250 MHz)
`define CLK_KHZ            250000

// Lamp timing in milliseconds
`define FLASH_ON_MS        250
`define FLASH_OFF_MS       250
`define FLASH_PAUSE_MS     1500
`define RESTORE_HOLD_MS    2000

// Lamp timing in clock cycles
`define FLASH_ON_CYC       (`FLASH_ON_MS * `CLK_KHZ)
`define FLASH_OFF_CYC      (`FLASH_OFF_MS * `CLK_KHZ)
`define FLASH_PAUSE_CYC    (`FLASH_PAUSE_MS * `CLK_KHZ)
`define RESTORE_HOLD_CYC   (`RESTORE_HOLD_MS * `CLK_KHZ)

// Number of flashes in the boot sequence
`define POST_FLASHES       3
// Cycles to let the pad synchronisers settle
`define STRAP_SETTLE       2'h3

// Register byte offsets
`define OFF_CTRL           12'h000
`define OFF_SETTINGS       12'h004
`define OFF_STATUS         12'h008
`define OFF_INT_STATUS     12'h00C
`define OFF_INT_ENABLE     12'h010
`define OFF_INT_CLEAR      12'h014

// Reset values
`define CTRL_RST           1'h0
`define POWER_LEVEL_RST    2'h3
`define INT_ENABLE_RST     4'h0

// Interrupt status bit positions
`define INT_FAULT_SET      0
`define INT_FAULT_CLR      1
`define INT_RESTORED       2
`define INT_RUN_CHANGE     3

`endif

/* File: fault_monitor_pkg.sv */
// Types shared by the fault monitor and lamp controller
package fault_monitor_pkg;

  // Analog monitor comparator outputs, high when the condition holds
  typedef struct packed {
    logic supply_over;
    logic supply_under;
    logic over_current;
    logic coil_high;
    logic temp_high;
    logic resonance_bad;
    logic duty_bad;
  } monitor_t;

  // Strap pads, low when shorted
  typedef struct packed {
    logic power_on_auto_run_n;
    logic skip_boot_flash_n;
    logic restore_n;
  } pads_t;

  // Everything that crosses in from the pins
  typedef struct packed {
    logic     button_n;
    logic     ext_run_n;
    logic     expansion_module;
    pads_t    pads;
    monitor_t mon;
  } pin_in_t;

  // Operating phase, one-hot
  typedef enum logic [3:0] {
    ST_STRAP = 4'h1,
    ST_POST  = 4'h2,
    ST_RUN   = 4'h4,
    ST_FAULT = 4'h8
  } mode_t;

endpackage

/* File: fault_monitor_led_status_ctrl.sv */
// Fault latch, start/stop control and status lamp sequencer with an APB register file
//
// Summary of operation
// - Boot test: basic flashes message lamp, extended flashes run lamp; other shows expansion.
// - Auto-run strap shorted: output enables by itself when start-up ends.
// - Skip-flash strap shorted: no lamp flash sequences at start-up.
// - Restore pad shorted two seconds outside a latched fault: user settings return to factory values.
// - After a restore the boot sequence plays, unless skip-flash strap is set.
// - Run lamp lit exactly while the output transistors are driven, except during the boot test.
// - Active fault shown as fault-code flashes on red lamp, then a pause, repeated.
// - Any fault disables the output at once and keeps it off while latched.
// - One button press clears a fault; a second press enables the output.
// - Supply above about 28 V or below minimum raises code 1.
// - Output current overload raises code 2.
// - Coil voltage above safe threshold raises code 3.
// - Board over-temperature raises code 4.
// - Resonance out of range or absent raises code 5.
// - Uneven transistor duty raises code 6.
// - External run input low inverts the button state; high leaves it.
// - Message lamp output pulses on errors, on start/stop presses and on settings-register writes in the run phase.
`timescale 1ns/1ps
`include "fault_monitor_defines.svh"

module fault_monitor_led_status_ctrl #(
  parameter int unsigned FLASH_ON_CYC    = `FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_CYC   = `FLASH_OFF_CYC,
  parameter int unsigned FLASH_PAUSE_CYC = `FLASH_PAUSE_CYC,
  parameter int unsigned RESTORE_CYC     = `RESTORE_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Pins: button, external run, expansion detect, straps, monitors
  input  wire fault_monitor_pkg::pin_in_t  pins,
  // Power stage and lamps
  output logic                             gate_enable,
  output logic                             run_lamp,
  output logic                             message_lamp,
  output logic                             message_lamp_out,
  // Interrupt
  output logic                             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants at counter width

  localparam logic [31:0] ON_LAST    = 32'(FLASH_ON_CYC - 1);
  localparam logic [31:0] OFF_LAST   = 32'(FLASH_OFF_CYC - 1);
  localparam logic [31:0] PAUSE_LAST = 32'(FLASH_PAUSE_CYC - 1);
  localparam logic [31:0] RST_LAST   = 32'(RESTORE_CYC - 1);
  localparam logic [31:0] PULSE_LEN  = 32'(FLASH_ON_CYC);
  localparam logic [2:0]  POST_N     = 3'(`POST_FLASHES);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    fault_monitor_pkg::mode_t   st;
    fault_monitor_pkg::pin_in_t s1;
    fault_monitor_pkg::pin_in_t s2;
    logic                       btn_prev;
    logic                       auto_run;
    logic                       skip_flash;
    logic [1:0]                 settle;
    logic [31:0]                timer;
    logic [2:0]                 flashes;
    logic                       lamp_on;
    logic                       run_on;
    logic [2:0]                 fault_code;
    logic [31:0]                rst_cnt;
    logic                       rst_hold;
    logic [1:0]                 power_level;
    logic                       variant;
    logic [3:0]                 int_status;
    logic [3:0]                 int_enable;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic                       gate;
    logic                       run_lamp;
    logic                       msg_lamp;
    logic                       msg_out;
    logic                       irq;
  } state_t;

  state_t s_reg;
  state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic       press;
    logic       ext_low;
    logic [2:0] hit;
    logic [3:0] events;
    logic [3:0] clr;
    logic       wr;
    logic       rd_ok;
    logic [31:0] rd;
    logic       post_flash;

    s_next  = s_reg;
    events  = 4'h0;
    clr     = 4'h0;
    rd      = 32'h0;
    rd_ok   = 1'b1;
    press      = 1'b0;
    ext_low    = 1'b0;
    hit        = 3'h0;
    wr         = 1'b0;
    post_flash = 1'b0;

    // Two-stage synchronisers on every pin
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;

    // Button press is a release-to-press edge
    press          = s_reg.btn_prev & ~s_reg.s2.button_n;
    s_next.btn_prev = s_reg.s2.button_n;
    ext_low        = ~s_reg.s2.ext_run_n;

    // Fault code from monitors, lowest code first
    if (s_reg.s2.mon.supply_over || s_reg.s2.mon.supply_under) begin
      hit = 3'h1;
    end else if (s_reg.s2.mon.over_current) begin
      hit = 3'h2;
    end else if (s_reg.s2.mon.coil_high) begin
      hit = 3'h3;
    end else if (s_reg.s2.mon.temp_high) begin
      hit = 3'h4;
    end else if (s_reg.s2.mon.resonance_bad) begin
      hit = 3'h5;
    end else if (s_reg.s2.mon.duty_bad) begin
      hit = 3'h6;
    end else begin
      hit = 3'h0;
    end

    // Phase sequencing
    case (s_reg.st)
      fault_monitor_pkg::ST_STRAP: begin
        // Wait for the synchronisers, then catch the straps
        s_next.settle = s_reg.settle + 2'h1;
        if (s_reg.settle == `STRAP_SETTLE) begin
          s_next.auto_run   = ~s_reg.s2.pads.power_on_auto_run_n;
          s_next.skip_flash = ~s_reg.s2.pads.skip_boot_flash_n;
          s_next.timer      = 32'h0;
          s_next.flashes    = 3'h0;
          s_next.lamp_on    = 1'b1;
          if (!s_reg.s2.pads.skip_boot_flash_n) begin
            s_next.st     = fault_monitor_pkg::ST_RUN;
            s_next.run_on = ~s_reg.s2.pads.power_on_auto_run_n;
          end else begin
            s_next.st = fault_monitor_pkg::ST_POST;
          end
        end
      end
      fault_monitor_pkg::ST_POST: begin
        // Boot flash sequence
        s_next.timer = s_reg.timer + 32'h1;
        if (s_reg.lamp_on) begin
          if (s_reg.timer == ON_LAST) begin
            s_next.timer   = 32'h0;
            s_next.lamp_on = 1'b0;
            s_next.flashes = s_reg.flashes + 3'h1;
          end
        end else if (s_reg.timer == OFF_LAST) begin
          s_next.timer = 32'h0;
          if (s_reg.flashes == POST_N) begin
            s_next.st     = fault_monitor_pkg::ST_RUN;
            s_next.run_on = s_reg.auto_run;
          end else begin
            s_next.lamp_on = 1'b1;
          end
        end
      end
      fault_monitor_pkg::ST_RUN: begin
        // Message pulse countdown and start/stop toggle
        if (s_reg.timer != 32'h0) begin
          s_next.timer = s_reg.timer - 32'h1;
        end
        if (press) begin
          s_next.run_on = ~s_reg.run_on;
          s_next.timer  = PULSE_LEN;
        end
      end
      fault_monitor_pkg::ST_FAULT: begin
        // Code flashes, then a pause, repeated
        s_next.timer = s_reg.timer + 32'h1;
        if (s_reg.lamp_on) begin
          if (s_reg.timer == ON_LAST) begin
            s_next.timer   = 32'h0;
            s_next.lamp_on = 1'b0;
            s_next.flashes = s_reg.flashes + 3'h1;
          end
        end else if (s_reg.flashes == s_reg.fault_code) begin
          if (s_reg.timer == PAUSE_LAST) begin
            s_next.timer   = 32'h0;
            s_next.flashes = 3'h0;
            s_next.lamp_on = 1'b1;
          end
        end else if (s_reg.timer == OFF_LAST) begin
          s_next.timer   = 32'h0;
          s_next.lamp_on = 1'b1;
        end
        // First press clears; output stays off until the next press
        if (press) begin
          s_next.st         = fault_monitor_pkg::ST_RUN;
          s_next.fault_code = 3'h0;
          s_next.run_on     = 1'b0;
          s_next.timer      = 32'h0;
          events[`INT_FAULT_CLR] = 1'b1;
        end
      end
      default: begin
        s_next.st = fault_monitor_pkg::ST_STRAP;
      end
    endcase

    // Any fault in the boot or run phase latches; a latched code is kept
    if (hit != 3'h0 &&
        (s_reg.st == fault_monitor_pkg::ST_POST ||
         s_reg.st == fault_monitor_pkg::ST_RUN)) begin
      s_next.st         = fault_monitor_pkg::ST_FAULT;
      s_next.fault_code = hit;
      s_next.run_on     = 1'b0;
      s_next.timer      = 32'h0;
      s_next.flashes    = 3'h0;
      s_next.lamp_on    = 1'b1;
      events[`INT_FAULT_SET] = 1'b1;
    end

    // Restore pad held low for the full time
    if (s_reg.s2.pads.restore_n) begin
      s_next.rst_cnt  = 32'h0;
      s_next.rst_hold = 1'b0;
    end else if (!s_reg.rst_hold) begin
      s_next.rst_cnt = s_reg.rst_cnt + 32'h1;
      if (s_reg.rst_cnt == RST_LAST && s_next.st != fault_monitor_pkg::ST_FAULT) begin
        s_next.rst_hold    = 1'b1;
        s_next.power_level = `POWER_LEVEL_RST;
        s_next.variant     = `CTRL_RST;
        s_next.int_enable  = `INT_ENABLE_RST;
        s_next.timer       = 32'h0;
        s_next.flashes     = 3'h0;
        s_next.lamp_on     = 1'b1;
        s_next.run_on      = 1'b0;
        s_next.st          = s_reg.skip_flash ? fault_monitor_pkg::ST_RUN
                                              : fault_monitor_pkg::ST_POST;
        events[`INT_RESTORED] = 1'b1;
      end
    end

    // APB: one wait state, then the answer
    wr = psel & penable & s_reg.pready & pwrite;
    if (paddr == `OFF_CTRL) begin
      rd = {31'h0, s_reg.variant};
    end else if (paddr == `OFF_SETTINGS) begin
      rd = {30'h0, s_reg.power_level};
    end else if (paddr == `OFF_STATUS) begin
      rd = {20'h0, s_reg.st, s_reg.skip_flash, s_reg.auto_run,
            s_reg.s2.expansion_module, s_reg.gate, 1'b0, s_reg.fault_code};
    end else if (paddr == `OFF_INT_STATUS) begin
      rd = {28'h0, s_reg.int_status};
    end else if (paddr == `OFF_INT_ENABLE) begin
      rd = {28'h0, s_reg.int_enable};
    end else if (paddr == `OFF_INT_CLEAR) begin
      rd = 32'h0;
    end else begin
      rd_ok = 1'b0;
    end
    s_next.pready = psel & penable & ~s_reg.pready;
    if (psel & penable & ~s_reg.pready) begin
      s_next.prdata  = pwrite ? 32'h0 : rd;
      s_next.pslverr = ~rd_ok;
    end else begin
      s_next.prdata  = 32'h0;
      s_next.pslverr = 1'b0;
    end
    if (wr) begin
      if (paddr == `OFF_CTRL) begin
        s_next.variant = pwdata[0];
      end else if (paddr == `OFF_SETTINGS) begin
        s_next.power_level = pwdata[1:0];
        if (s_next.st == fault_monitor_pkg::ST_RUN) begin
          s_next.timer = PULSE_LEN;
        end
      end else if (paddr == `OFF_INT_ENABLE) begin
        s_next.int_enable = pwdata[3:0];
      end else if (paddr == `OFF_INT_CLEAR) begin
        clr = pwdata[3:0];
      end
    end

    // Output drive: button state inverted by external run input
    s_next.gate = (s_next.st == fault_monitor_pkg::ST_RUN) &
                  (s_next.run_on ^ ext_low);
    if (s_next.gate != s_reg.gate) begin
      events[`INT_RUN_CHANGE] = 1'b1;
    end

    // Lamps per phase
    post_flash = s_next.lamp_on & ~s_reg.skip_flash;
    case (s_next.st)
      fault_monitor_pkg::ST_POST: begin
        s_next.run_lamp = s_next.variant ? post_flash
                                         : s_reg.s2.expansion_module;
        s_next.msg_lamp = s_next.variant ? s_reg.s2.expansion_module
                                         : post_flash;
      end
      fault_monitor_pkg::ST_RUN: begin
        s_next.run_lamp = s_next.gate;
        s_next.msg_lamp = s_next.timer != 32'h0;
      end
      fault_monitor_pkg::ST_FAULT: begin
        s_next.run_lamp = s_next.gate;
        s_next.msg_lamp = s_next.lamp_on;
      end
      default: begin
        s_next.run_lamp = 1'b0;
        s_next.msg_lamp = 1'b0;
      end
    endcase
    s_next.msg_out = s_next.msg_lamp;

    // Sticky interrupt bits; a new event wins over a clear
    s_next.int_status = (s_reg.int_status & ~clr) | events;
    s_next.irq        = |(s_next.int_status & s_next.int_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg             <= '0;
      s_reg.st          <= fault_monitor_pkg::ST_STRAP;
      s_reg.s1          <= '1;
      s_reg.s2          <= '1;
      s_reg.btn_prev    <= 1'b1;
      s_reg.power_level <= `POWER_LEVEL_RST;
      s_reg.variant     <= `CTRL_RST;
      s_reg.int_enable  <= `INT_ENABLE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign prdata           = s_reg.prdata;
  assign pready           = s_reg.pready;
  assign pslverr          = s_reg.pslverr;
  assign gate_enable      = s_reg.gate;
  assign run_lamp         = s_reg.run_lamp;
  assign message_lamp     = s_reg.msg_lamp;
  assign message_lamp_out = s_reg.msg_out;
  assign irq              = s_reg.irq;

endmodule

/* File: panel_model.sv */
// Behavioural panel: start/stop button, external run line, strap pads and monitors
`timescale 1ns/1ps
module panel_model (
  // Requests from the bench
  input  wire logic                  button_down,
  input  wire logic                  ext_run_low,
  input  wire logic                  expansion,
  input  wire logic [2:0]            straps,
  input  wire logic [6:0]            trip,
  // Pins toward the device
  output fault_monitor_pkg::pin_in_t pins
);
  // Button, external line and pads read low when active; trip[0] is undervoltage
  assign pins = {~button_down,
                 ~ext_run_low,
                 expansion,
                 ~straps,
                 trip[1], trip[0], trip[2], trip[3], trip[4], trip[5], trip[6]};
endmodule

/* File: fault_monitor_props.sv */
// Concurrent checks on the fault monitor and lamp controller ports
`timescale 1ns/1ps
module fault_monitor_checker (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB slave
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Pins and outputs
  input wire fault_monitor_pkg::pin_in_t pins,
  input wire logic                       gate_enable,
  input wire logic                       run_lamp,
  input wire logic                       message_lamp,
  input wire logic                       message_lamp_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  gate_lamp_a: assert property (gate_enable |-> run_lamp)
    else $error("green lamp dark while output is driven");
  fault_cut_a: assert property ((|pins.mon) |-> ##4 !gate_enable)
    else $error("output still driven after a monitor trip");
  fault_lamp_a: assert property (gate_enable && $rose(|pins.mon) |-> ##[1:4] message_lamp)
    else $error("red lamp not lit after a trip");
  msg_copy_a: assert property (message_lamp |-> ##[0:1] message_lamp_out)
    else $error("message output does not follow the red lamp");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_time_a: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not in second access cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
endmodule

bind fault_monitor_led_status_ctrl fault_monitor_checker checker_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .gate_enable(gate_enable),
  .run_lamp(run_lamp), .message_lamp(message_lamp), .message_lamp_out(message_lamp_out));

/* File: fault_monitor_led_status_ctrl_tb_top.sv */
// Testbench for the fault monitor and lamp controller
`timescale 1ns/1ps
module fault_monitor_led_status_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic gate_enable, run_lamp, message_lamp, message_lamp_out, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic btn, ext_lo, exp_det, err, last, flash_seen;
  logic [2:0] straps;
  logic [6:0] trip;
  fault_monitor_pkg::pin_in_t pins;
  int errors, comparisons, n, code;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and panel
  initial pclk = 1'h0;
  always #2 pclk = ~pclk;
  fault_monitor_led_status_ctrl #(.FLASH_ON_CYC(8), .FLASH_OFF_CYC(8),
    .FLASH_PAUSE_CYC(24), .RESTORE_CYC(40)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .gate_enable(gate_enable), .run_lamp(run_lamp),
    .message_lamp(message_lamp), .message_lamp_out(message_lamp_out), .irq(irq));
  panel_model model_u (.button_down(btn), .ext_run_low(ext_lo), .expansion(exp_det),
    .straps(straps), .trip(trip), .pins(pins));
  // Notes any red lamp activity since the last reset
  always @(posedge pclk) flash_seen <= !presetn ? 1'h0 : (flash_seen | (message_lamp === 1'h1));

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; rd and err take the answer
  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Polls the phase field; a phase that never comes runs into the watchdog
  task wait_state(input logic [3:0] s);
    do begin
      apb(1'h0, 12'h008, 32'h0);
    end while (rd[11:8] !== s);
  endtask
  task wait_lamp(input logic red);
    while ((red ? message_lamp : run_lamp) !== 1'h1) begin
      @(posedge pclk);
    end
  endtask
  task press;
    @(posedge pclk);
    btn <= 1'h1;
    repeat (4) @(posedge pclk);
    btn <= 1'h0;
    repeat (6) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {errors, comparisons} = 0;
    {psel, penable, pwrite, paddr, pwdata, btn, ext_lo, straps, trip} = '0;
    exp_det = 1'h1;
    presetn = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    // Extended variant boot: green flashes, red shows expansion
    apb(1'h1, 12'h000, 32'h1);
    wait_lamp(1'h0);
    chk(message_lamp, 1'h1);
    wait_state(4'h4);
    chk(gate_enable, 1'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, 12'h004, 32'h1);
    repeat (2) @(posedge pclk);
    chk(message_lamp_out, 1'h1);
    apb(1'h0, 12'h018, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
    press;
    chk({gate_enable, run_lamp}, 2'h3);
    ext_lo <= 1'h1;
    repeat (6) @(posedge pclk);
    chk({gate_enable, run_lamp}, 2'h0);
    ext_lo <= 1'h0;
    repeat (6) @(posedge pclk);
    chk(gate_enable, 1'h1);
    apb(1'h1, 12'h010, 32'h1);
    // Every fault code: flash count, cut-off, latch, interrupt, two-press restart
    for (int c = 0; c <= 6; c++) begin
      code = (c == 0) ? 1 : c;
      // Let the message pulse of the last start press die out first
      repeat (12) @(posedge pclk);
      trip[c] <= 1'h1;
      n = 0;
      last = 1'h0;
      repeat ((code + 1) * 16) begin
        @(posedge pclk);
        if (message_lamp === 1'h1 && !last) n++;
        last = message_lamp;
      end
      chk(n, code);
      chk(gate_enable, 1'h0);
      apb(1'h0, 12'h008, 32'h0);
      chk(rd[2:0], code[2:0]);
      chk(irq, 1'h1);
      apb(1'h1, 12'h014, 32'hF);
      repeat (2) @(posedge pclk);
      chk(irq, 1'h0);
      trip <= 7'h0;
      press;
      chk(gate_enable, 1'h0);
      press;
      chk(gate_enable, 1'h1);
    end
    // Second fault while one is latched, interrupt masked
    apb(1'h1, 12'h010, 32'h0);
    trip[4] <= 1'h1;
    repeat (8) @(posedge pclk);
    trip[2] <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[2:0], 3'h4);
    chk(irq, 1'h0);
    trip <= 7'h0;
    press;
    press;
    // Restore pad held: settings back, basic boot replays
    straps <= 3'h1;
    repeat (50) @(posedge pclk);
    straps <= 3'h0;
    wait_state(4'h2);
    wait_lamp(1'h1);
    chk(run_lamp, 1'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h3);
    wait_state(4'h4);
    chk(gate_enable, 1'h0);
    // Reset again with auto-run and skip-flash straps shorted
    presetn <= 1'h0;
    straps <= 3'h6;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    wait_state(4'h4);
    repeat (4) @(posedge pclk);
    chk(gate_enable, 1'h1);
    chk(flash_seen, 1'h0);
    end_of_test;
  end
endmodule
